// File: upf_framer.v
// Serial packet framer with port dispatch
`timescale 1ns/1ns
`include "upf_regs.vh"
module upf_framer #(
	parameter LED_TICK_CYC = (`UPF_CLK_HZ / 1000) * `UPF_LED_MS
) (
	input  wire        CLK_I,
	input  wire        RESET_N_I,
	input  wire        UART_RX_I,
	output wire        UART_TX_O,
	input  wire [3:0]  BAUD_SEL_I,
	input  wire [15:0] OWN_ADDR_I,
	output wire        NET_OUT_VALID_O,
	output wire [7:0]  NET_OUT_DATA_O,
	output wire        NET_OUT_LAST_O,
	input  wire        NET_OUT_READY_I,
	input  wire        NET_IN_VALID_I,
	input  wire [7:0]  NET_IN_DATA_I,
	input  wire        NET_IN_LAST_I,
	output wire        NET_IN_READY_O,
	output wire        LED_RED_O,
	output wire        FRAME_DROP_O
);
	localparam [1:0] U_IDLE = 2'h0, U_START = 2'h1, U_DATA = 2'h2, U_STOP = 2'h3;
	localparam [1:0] P_HUNT = 2'h0, P_LEN = 2'h1, P_BODY = 2'h2;
	localparam [1:0] E_IDLE = 2'h0, E_FWD = 2'h1, E_TX = 2'h2;
	localparam [1:0] S_RX = 2'h0, S_NET = 2'h1, S_ERR = 2'h2;
	localparam [2:0] T_HEAD = 3'h0, T_LEN = 3'h1, T_BODY = 3'h2, T_ESC = 3'h3, T_TERM = 3'h4;
	localparam [31:0] LED_TOP = LED_TICK_CYC - 1;

	function [31:0] baud_div;
		input [3:0] sel;
		begin
			case (sel)
			4'h0: baud_div = `UPF_CLK_HZ / 2400;
			4'h1: baud_div = `UPF_CLK_HZ / 4800;
			4'h2: baud_div = `UPF_CLK_HZ / 9600;
			4'h3: baud_div = `UPF_CLK_HZ / 14400;
			4'h4: baud_div = `UPF_CLK_HZ / 19200;
			4'h5: baud_div = `UPF_CLK_HZ / 28800;
			4'h6: baud_div = `UPF_CLK_HZ / 38400;
			4'h7: baud_div = `UPF_CLK_HZ / 57600;
			4'h9: baud_div = `UPF_CLK_HZ / 230400;
			4'hA: baud_div = `UPF_CLK_HZ / 125000;
			4'hB: baud_div = `UPF_CLK_HZ / 250000;
			4'hC: baud_div = `UPF_CLK_HZ / 500000;
			default: baud_div = `UPF_CLK_HZ / 115200;
			endcase
		end
	endfunction

	reg  [3:0]  baud_s1_ff, baud_s2_ff;
	reg  [15:0] own_s1_ff, own_s2_ff;
	wire [31:0] div32 = baud_div(baud_s2_ff);
	wire [15:0] div   = div32[15:0];

	// Serial receiver
	reg        rx_s1_ff, rx_s2_ff, rx_s3_ff;
	reg [1:0]  u_st_ff;
	reg [15:0] u_cnt_ff;
	reg [2:0]  u_bit_ff;
	reg [7:0]  u_sh_ff;
	reg        rx_vld_ff;
	reg [7:0]  rx_dat_ff;

	always @(posedge CLK_I) begin
		rx_s1_ff <= UART_RX_I;
		rx_s2_ff <= rx_s1_ff;
		rx_s3_ff <= rx_s2_ff;
		baud_s1_ff <= BAUD_SEL_I;
		baud_s2_ff <= baud_s1_ff;
		own_s1_ff  <= OWN_ADDR_I;
		own_s2_ff  <= own_s1_ff;
		if (!RESET_N_I) begin
			u_st_ff   <= U_IDLE;
			u_cnt_ff  <= 16'h0000;
			u_bit_ff  <= 3'h0;
			u_sh_ff   <= 8'h00;
			rx_vld_ff <= 1'b0;
			rx_dat_ff <= 8'h00;
		end else begin
			rx_vld_ff <= 1'b0;
			if (u_st_ff == U_IDLE) begin
				if (rx_s3_ff & !rx_s2_ff) begin
					u_st_ff  <= U_START;
					u_cnt_ff <= {1'b0, div[15:1]};
				end
			end else if (u_cnt_ff != 16'h0000) begin
				u_cnt_ff <= u_cnt_ff - 16'h0001;
			end else begin
				u_cnt_ff <= div - 16'h0001;
				case (u_st_ff)
				U_START: begin
					u_st_ff  <= rx_s2_ff ? U_IDLE : U_DATA;
					u_bit_ff <= 3'h0;
				end
				U_DATA: begin
					u_sh_ff  <= {rx_s2_ff, u_sh_ff[7:1]};
					u_bit_ff <= u_bit_ff + 3'h1;
					if (u_bit_ff == 3'h7) begin
						u_st_ff <= U_STOP;
					end
				end
				default: begin
					u_st_ff   <= U_IDLE;
					rx_vld_ff <= rx_s2_ff;
					rx_dat_ff <= u_sh_ff;
				end
				endcase
			end
		end
	end

	// Frame parser with unescaping
	reg [7:0] rbuf_ff [0:63];
	reg [1:0] p_st_ff;
	reg       p_esc_ff;
	reg [7:0] p_len_ff;
	reg [7:0] p_cnt_ff;
	reg       p_bad_ff;
	reg       drop_ff;
	reg       rx_full_ff;
	reg [7:0] rx_len_ff;
	wire [7:0] b = rx_dat_ff;
	wire is_hd = (b == `UPF_HEAD);
	wire is_tm = (b == `UPF_TERM);
	wire is_es = (b == `UPF_ESC_FF) | (b == `UPF_ESC_FE);
	wire p_head = rx_vld_ff & !p_esc_ff & is_hd;
	wire p_term = rx_vld_ff & is_tm;
	wire p_put  = rx_vld_ff & (p_st_ff == P_BODY) & (p_esc_ff ? is_es : !is_hd & !is_tm);
	wire p_lenb = rx_vld_ff & (p_esc_ff ? (!is_es & !is_tm) : (p_st_ff == P_LEN) & !is_hd & !is_tm);
	wire [7:0] p_val = !p_esc_ff ? b : (b == `UPF_ESC_FF) ? `UPF_TERM : `UPF_HEAD;
	wire len_ok = (b >= `UPF_LEN_OVH) & (b <= `UPF_LEN_MAX) & !rx_full_ff;
	wire p_done = p_term & !p_esc_ff & (p_st_ff == P_BODY) & !p_bad_ff & (p_cnt_ff == p_len_ff);

	always @(posedge CLK_I) begin
		if (p_put & (p_cnt_ff < p_len_ff)) begin
			rbuf_ff[p_cnt_ff[5:0]] <= p_val;
		end
		if (!RESET_N_I) begin
			p_st_ff  <= P_HUNT;
			p_esc_ff <= 1'b0;
			p_len_ff <= 8'h00;
			p_cnt_ff <= 8'h00;
			p_bad_ff <= 1'b0;
			drop_ff  <= 1'b0;
		end else begin
			drop_ff <= 1'b0;
			if (rx_vld_ff & p_esc_ff) begin
				p_esc_ff <= 1'b0;
			end
			if (p_head) begin
				if (p_st_ff == P_BODY) begin
					p_esc_ff <= 1'b1;
				end else begin
					p_st_ff <= P_LEN;
				end
			end
			if (p_lenb) begin
				drop_ff  <= (p_st_ff == P_BODY);
				p_st_ff  <= len_ok ? P_BODY : P_HUNT;
				p_len_ff <= b;
				p_cnt_ff <= 8'h00;
				p_bad_ff <= 1'b0;
			end
			if (p_put) begin
				if (p_cnt_ff == p_len_ff) begin
					p_bad_ff <= 1'b1;
				end else begin
					p_cnt_ff <= p_cnt_ff + 8'h01;
				end
			end
			if (p_term) begin
				p_st_ff <= P_HUNT;
				drop_ff <= !p_done & (p_st_ff != P_HUNT);
			end
		end
	end

	// Frames arriving from the network side
	reg [7:0] nbuf_ff [0:63];
	reg [6:0] n_cnt_ff;
	reg       net_full_ff;
	reg [7:0] n_len_ff;
	wire n_acc = NET_IN_VALID_I & !net_full_ff;
	wire [7:0] n_nxt = {1'b0, n_cnt_ff} + 8'h01;
	wire n_done = n_acc & NET_IN_LAST_I & (n_nxt >= `UPF_LEN_OVH) & (n_nxt <= `UPF_LEN_MAX);
	assign NET_IN_READY_O = !net_full_ff;

	always @(posedge CLK_I) begin
		if (n_acc & (n_cnt_ff < 7'h3F)) begin
			nbuf_ff[n_cnt_ff[5:0]] <= NET_IN_DATA_I;
		end
		if (!RESET_N_I) begin
			n_cnt_ff <= 7'h00;
			n_len_ff <= 8'h00;
		end else if (n_acc) begin
			n_cnt_ff <= NET_IN_LAST_I ? 7'h00 : (n_cnt_ff == 7'h7F ? n_cnt_ff : n_nxt[6:0]);
			if (n_done) begin
				n_len_ff <= n_nxt;
			end
		end
	end

	// Dispatch engine
	reg [1:0] e_st_ff;
	reg [1:0] src_ff;
	reg [2:0] t_ph_ff;
	reg [7:0] idx_ff;
	reg [9:0] tx_sh_ff;
	reg [3:0] tx_n_ff;
	reg [15:0] tx_cnt_ff;
	reg [7:0] led_rem_ff;
	reg [23:0] led_tick_ff;
	reg [7:0] c;
	reg [7:0] nxt_tx_byte;

	wire [7:0]  r_src  = rbuf_ff[`UPF_IDX_SRC];
	wire [7:0]  r_dst  = rbuf_ff[`UPF_IDX_DST];
	wire [15:0] r_addr = {rbuf_ff[`UPF_IDX_AHI], rbuf_ff[`UPF_IDX_ALO]};
	wire r_loc   = (r_addr == `UPF_LOCAL) | (r_addr == own_s2_ff);
	wire dec_rx  = (e_st_ff == E_IDLE) & rx_full_ff;
	wire dec_net = (e_st_ff == E_IDLE) & !rx_full_ff & net_full_ff;
	wire rx_err  = r_src < `UPF_HOST_PORT;
	wire rx_int  = !rx_err & (r_dst < `UPF_HOST_PORT) & r_loc;
	wire rx_loop = !rx_err & (r_dst >= `UPF_HOST_PORT) & (r_addr == own_s2_ff);
	wire net_int = nbuf_ff[`UPF_IDX_DST] < `UPF_HOST_PORT;
	wire led_rx  = dec_rx & rx_int & (r_dst == `UPF_LED_PORT) & (rx_len_ff > `UPF_LEN_OVH);
	wire led_net = dec_net & net_int & (nbuf_ff[`UPF_IDX_DST] == `UPF_LED_PORT) & (n_len_ff > `UPF_LEN_OVH);
	wire [7:0] led_val = led_rx ? rbuf_ff[`UPF_IDX_PAY] : nbuf_ff[`UPF_IDX_PAY];
	wire [7:0] t_len = (src_ff == S_RX) ? rx_len_ff : (src_ff == S_NET) ? n_len_ff : `UPF_ERR_LEN;
	wire last_b = (idx_ff == t_len - 8'h01);
	wire c_esc  = (c == `UPF_TERM) | (c == `UPF_HEAD);
	wire tx_go  = (e_st_ff == E_TX) & (tx_n_ff == 4'h0);
	wire f_rdy;
	wire f_push = (e_st_ff == E_FWD) & f_rdy;

	always @* begin
		c = rbuf_ff[idx_ff[5:0]];
		if (src_ff == S_NET) begin
			c = nbuf_ff[idx_ff[5:0]];
		end else if (src_ff == S_ERR) begin
			case (idx_ff)
			8'h00: c = `UPF_ERR_SRC;
			8'h04: c = `UPF_ERR_CODE;
			8'h05: c = r_src;
			default: c = rbuf_ff[idx_ff[5:0]];
			endcase
		end
		case (t_ph_ff)
		T_HEAD: nxt_tx_byte = `UPF_HEAD;
		T_LEN: nxt_tx_byte = t_len;
		T_BODY: nxt_tx_byte = c_esc ? `UPF_HEAD : c;
		T_ESC: nxt_tx_byte = (c == `UPF_TERM) ? `UPF_ESC_FF : `UPF_ESC_FE;
		default: nxt_tx_byte = `UPF_TERM;
		endcase
	end

	always @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			e_st_ff     <= E_IDLE;
			src_ff      <= S_RX;
			t_ph_ff     <= T_HEAD;
			idx_ff      <= 8'h00;
			rx_full_ff  <= 1'b0;
			rx_len_ff   <= 8'h00;
			net_full_ff <= 1'b0;
		end else begin
			if (p_done) begin
				rx_full_ff <= 1'b1;
				rx_len_ff  <= p_len_ff;
			end
			if (n_done) begin
				net_full_ff <= 1'b1;
			end
			case (e_st_ff)
			E_IDLE: begin
				idx_ff  <= 8'h00;
				t_ph_ff <= T_HEAD;
				if (dec_rx) begin
					if (rx_err | rx_loop) begin
						src_ff  <= rx_err ? S_ERR : S_RX;
						e_st_ff <= E_TX;
					end else if (rx_int) begin
						rx_full_ff <= 1'b0;
					end else begin
						e_st_ff <= E_FWD;
					end
				end else if (dec_net) begin
					if (net_int) begin
						net_full_ff <= 1'b0;
					end else begin
						src_ff  <= S_NET;
						e_st_ff <= E_TX;
					end
				end
			end
			E_FWD: begin
				if (f_push) begin
					idx_ff <= idx_ff + 8'h01;
					if (idx_ff == rx_len_ff - 8'h01) begin
						rx_full_ff <= 1'b0;
						e_st_ff    <= E_IDLE;
					end
				end
			end
			E_TX: begin
				if (tx_go) begin
					case (t_ph_ff)
					T_HEAD: t_ph_ff <= T_LEN;
					T_LEN: t_ph_ff <= T_BODY;
					T_BODY, T_ESC: begin
						if (t_ph_ff == T_BODY & c_esc) begin
							t_ph_ff <= T_ESC;
						end else begin
							idx_ff  <= idx_ff + 8'h01;
							t_ph_ff <= last_b ? T_TERM : T_BODY;
						end
					end
					default: begin
						e_st_ff <= E_IDLE;
						if (src_ff == S_NET) begin
							net_full_ff <= 1'b0;
						end else begin
							rx_full_ff <= 1'b0;
						end
					end
					endcase
				end
			end
			default: e_st_ff <= E_IDLE;
			endcase
		end
	end

	// Serial transmitter
	always @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			tx_sh_ff  <= 10'h3FF;
			tx_n_ff   <= 4'h0;
			tx_cnt_ff <= 16'h0000;
		end else if (tx_go) begin
			tx_sh_ff  <= {1'b1, nxt_tx_byte, 1'b0};
			tx_n_ff   <= 4'hA;
			tx_cnt_ff <= div - 16'h0001;
		end else if (tx_n_ff != 4'h0) begin
			if (tx_cnt_ff == 16'h0000) begin
				tx_sh_ff  <= {1'b1, tx_sh_ff[9:1]};
				tx_n_ff   <= tx_n_ff - 4'h1;
				tx_cnt_ff <= div - 16'h0001;
			end else begin
				tx_cnt_ff <= tx_cnt_ff - 16'h0001;
			end
		end
	end
	assign UART_TX_O = tx_sh_ff[0];

	// Red indicator timer
	always @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			led_rem_ff  <= 8'h00;
			led_tick_ff <= 24'h000000;
		end else if (led_rx | led_net) begin
			led_rem_ff  <= led_val;
			led_tick_ff <= 24'h000000;
		end else if (led_rem_ff != 8'h00) begin
			if (led_tick_ff == LED_TOP[23:0]) begin
				led_tick_ff <= 24'h000000;
				led_rem_ff  <= led_rem_ff - 8'h01;
			end else begin
				led_tick_ff <= led_tick_ff + 24'h000001;
			end
		end
	end
	assign LED_RED_O    = (led_rem_ff != 8'h00);
	assign FRAME_DROP_O = drop_ff;

	upf_fifo #(
		.W  (9),
		.D  (8),
		.AW (3)
	) u_fifo (
		.clk_i       (CLK_I),
		.reset_n_i   (RESET_N_I),
		.in_valid_i  (e_st_ff == E_FWD),
		.in_ready_o  (f_rdy),
		.in_data_i   ({idx_ff == rx_len_ff - 8'h01, rbuf_ff[idx_ff[5:0]]}),
		.out_valid_o (NET_OUT_VALID_O),
		.out_ready_i (NET_OUT_READY_I),
		.out_data_o  ({NET_OUT_LAST_O, NET_OUT_DATA_O})
	);
endmodule

// File: upf_regs.vh
// Constants of the serial packet framer
// Functional notes
// - Characters are 8N1, both directions
// - Baud chosen from fixed rate table
// - Frame opens with FE then length
// - Length equals payload count plus four
// - Order: src, dst, address, payload, terminator
// - FF terminator completes one frame
// - Address sent low byte first
// - Escape FF as FE FD, FE as FE FC
// - Length counts bytes before escaping
// - Host address names destination, 0000 means local
// - Host-bound address holds originating node
// - Received frames dispatched by destination port
// - Ports below 80 internal, rest host
// - Host source port below 80 not sent
// - Rejected source returns E0 report frame
// - Internal-port frames reach serial output only as E0 reports
// - Own address, host port: loop back
// - Port 20 lights LED payload times 100ms
// - Counted length never exceeds 63
`ifndef UPF_REGS_VH
`define UPF_REGS_VH
`define UPF_HEAD      8'hFE
`define UPF_TERM      8'hFF
`define UPF_ESC_FF    8'hFD
`define UPF_ESC_FE    8'hFC
`define UPF_LEN_OVH   8'h04
`define UPF_LEN_MAX   8'h3F
`define UPF_HOST_PORT 8'h80
`define UPF_LED_PORT  8'h20
`define UPF_ERR_CODE  8'hE0
`define UPF_ERR_SRC   8'h22
`define UPF_ERR_LEN   8'h06
`define UPF_LOCAL     16'h0000
`define UPF_IDX_SRC   0
`define UPF_IDX_DST   1
`define UPF_IDX_ALO   2
`define UPF_IDX_AHI   3
`define UPF_IDX_PAY   4
`define UPF_CLK_HZ    100000000
`define UPF_LED_MS    100
`endif

// File: upf_fifo.v
// Byte FIFO toward the network side
`timescale 1ns/1ns
module upf_fifo #(
	parameter W  = 9,
	parameter D  = 8,
	parameter AW = 3
) (
	input  wire         clk_i,
	input  wire         reset_n_i,
	input  wire         in_valid_i,
	output wire         in_ready_o,
	input  wire [W-1:0] in_data_i,
	output wire         out_valid_o,
	input  wire         out_ready_i,
	output wire [W-1:0] out_data_o
);
	reg [W-1:0] mem_ff [0:D-1];
	reg [AW-1:0] wr_ff;
	reg [AW-1:0] rd_ff;
	reg [AW:0]   cnt_ff;
	wire         push;
	wire         pop;
	localparam [AW:0] FULL = D;

	assign in_ready_o  = (cnt_ff != FULL);
	assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
	assign out_data_o  = mem_ff[rd_ff];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always @(posedge clk_i) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data_i;
		end
		if (!reset_n_i) begin
			wr_ff  <= {AW{1'b0}};
			rd_ff  <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ff <= wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= rd_ff + 1'b1;
			end
			if (push & !pop) begin
				cnt_ff <= cnt_ff + 1'b1;
			end else if (pop & !push) begin
				cnt_ff <= cnt_ff - 1'b1;
			end
		end
	end
endmodule

// File: upf_framer_props.sv
// Port checker for the packet framer
`timescale 1ns/1ns
module upf_props #(
	parameter LED_TICK_CYC = 10,
	parameter BIT_CYC      = 200
) (
	input wire       CLK_I,
	input wire       RESET_N_I,
	input wire       UART_TX_O,
	input wire       NET_OUT_VALID_O,
	input wire [7:0] NET_OUT_DATA_O,
	input wire       NET_OUT_LAST_O,
	input wire       NET_OUT_READY_I,
	input wire       NET_IN_VALID_I,
	input wire       NET_IN_LAST_I,
	input wire       NET_IN_READY_O,
	input wire       LED_RED_O,
	input wire       FRAME_DROP_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RESET_N_I);
	reg  [15:0] low_ff;
	reg  [31:0] led_ff;
	reg  [7:0]  cnt_ff;
	wire        take = NET_OUT_VALID_O && NET_OUT_READY_I;
	// Low run on the serial line, lit time, content bytes taken
	always @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			low_ff <= 16'h0;
			led_ff <= 32'h0;
			cnt_ff <= 8'h0;
		end else begin
			low_ff <= UART_TX_O ? 16'h0 : low_ff + 16'h1;
			led_ff <= LED_RED_O ? led_ff + 32'h1 : 32'h0;
			if (take)
				cnt_ff <= NET_OUT_LAST_O ? 8'h0 : cnt_ff + 8'h1;
		end
	end
	AST_BIT_TIME: assert property ($rose(UART_TX_O) |-> low_ff != 0 && low_ff % BIT_CYC == 0)
		else $error("serial low run not whole bits");
	AST_STOP_BIT: assert property (low_ff <= 9 * BIT_CYC)
		else $error("serial line low past stop bit");
	AST_NET_HOLD: assert property (NET_OUT_VALID_O && !NET_OUT_READY_I |=>
		NET_OUT_VALID_O && $stable(NET_OUT_DATA_O) && $stable(NET_OUT_LAST_O))
		else $error("network byte changed while stalled");
	AST_NET_LEN: assert property (take && NET_OUT_LAST_O |-> cnt_ff >= 3 && cnt_ff <= 62)
		else $error("forwarded frame size out of range");
	AST_NET_SRC: assert property (take && cnt_ff == 0 |-> NET_OUT_DATA_O >= 8'h80)
		else $error("internal source port forwarded");
	AST_LED_TIME: assert property ($fell(LED_RED_O) |-> led_ff >= LED_TICK_CYC)
		else $error("indicator lit under one tick");
	AST_DROP_PULSE: assert property (FRAME_DROP_O |=> !FRAME_DROP_O)
		else $error("drop pulse longer than one cycle");
	AST_NETIN_RDY: assert property (NET_IN_VALID_I && NET_IN_READY_O && NET_IN_LAST_I |=> !NET_IN_READY_O)
		else $error("network input ready after last");
	cover property ($rose(LED_RED_O));
	cover property (take && NET_OUT_LAST_O);
	cover property (FRAME_DROP_O);
endmodule
bind upf_framer upf_props #(.LED_TICK_CYC(LED_TICK_CYC)) i_props (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
	.UART_TX_O(UART_TX_O), .NET_OUT_VALID_O(NET_OUT_VALID_O), .NET_OUT_DATA_O(NET_OUT_DATA_O),
	.NET_OUT_LAST_O(NET_OUT_LAST_O), .NET_OUT_READY_I(NET_OUT_READY_I), .NET_IN_VALID_I(NET_IN_VALID_I),
	.NET_IN_LAST_I(NET_IN_LAST_I), .NET_IN_READY_O(NET_IN_READY_O), .LED_RED_O(LED_RED_O),
	.FRAME_DROP_O(FRAME_DROP_O));

// File: upf_host.sv
// Host serial model: 8N1 sender and receiver
`timescale 1ns/1ns
module upf_host #(
	parameter DIV = 200
) (
	input  wire clk_i,
	input  wire line_i,
	output reg  line_o
);
	logic [7:0] rx_q[$];
	logic [7:0] sh;
	initial line_o = 1'b1;
	task automatic put_byte(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge clk_i);
			line_o = fr[i];
			repeat (DIV - 1) @(negedge clk_i);
		end
	endtask
	// Bytes kept only with a good stop bit
	always begin
		@(negedge line_i);
		repeat (DIV / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (DIV) @(posedge clk_i);
			sh[i] = line_i;
		end
		repeat (DIV) @(posedge clk_i);
		if (line_i === 1'b1)
			rx_q.push_back(sh);
	end
endmodule

// File: upf_tb.sv
// Self-checking bench for the packet framer
`timescale 1ns/1ns
module testbench;
	typedef logic [8:0] upf_bq_t[$];
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       o_rdy = 1'b0;
	logic       i_vld = 1'b0;
	logic [7:0] i_dat = 8'h00;
	logic       i_last = 1'b0;
	wire        rx, tx, o_vld, o_last, i_rdy, led, drop;
	wire  [7:0] o_dat;
	int         fail_count = 0;
	int         tests_run = 0;
	int         led_n = 0;
	int         drop_n = 0;
	upf_bq_t    net_q;
	always #5 clk = ~clk;
	upf_framer #(.LED_TICK_CYC(10)) i_dut (.CLK_I(clk), .RESET_N_I(rst_n), .UART_RX_I(rx), .UART_TX_O(tx),
		.BAUD_SEL_I(4'hC), .OWN_ADDR_I(16'h000F), .NET_OUT_VALID_O(o_vld), .NET_OUT_DATA_O(o_dat),
		.NET_OUT_LAST_O(o_last), .NET_OUT_READY_I(o_rdy), .NET_IN_VALID_I(i_vld), .NET_IN_DATA_I(i_dat),
		.NET_IN_LAST_I(i_last), .NET_IN_READY_O(i_rdy), .LED_RED_O(led), .FRAME_DROP_O(drop));
	upf_host i_host (.clk_i(clk), .line_i(tx), .line_o(rx));
	always @(posedge clk) begin
		if (o_vld && o_rdy)
			net_q.push_back({o_last, o_dat});
		if (led === 1'b1)
			led_n++;
		if (drop === 1'b1)
			drop_n++;
	end
	task automatic chkv(input logic [8:0] got, input logic [8:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic ok);
		tests_run++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("CHECK FAILED t=%0t condition false", $time);
		end
	endtask
	task automatic send(input upf_bq_t q);
		foreach (q[i])
			i_host.put_byte(q[i][7:0]);
	endtask
	task automatic host_exp(input upf_bq_t q);
		int n;
		n = 0;
		while (i_host.rx_q.size() < q.size() && n < 30000) begin
			@(posedge clk);
			n++;
		end
		chk1(i_host.rx_q.size() == q.size());
		foreach (q[i])
			if (i < i_host.rx_q.size())
				chkv({1'b0, i_host.rx_q[i]}, q[i]);
		i_host.rx_q.delete();
	endtask
	task automatic net_exp(input upf_bq_t q);
		chk1(net_q.size() == q.size());
		foreach (q[i])
			if (i < net_q.size())
				chkv(net_q[i], q[i]);
		net_q.delete();
	endtask
	task automatic t_fwd;
		send('{8'hFE, 8'h08, 8'h91, 8'hA0, 8'h03, 8'h00, 8'hFE, 8'hFC, 8'hFE, 8'hFD, 8'h11, 8'h22, 8'hFF});
		repeat (100) @(negedge clk);
		chk1(o_vld === 1'b1 && net_q.size() == 0);
		o_rdy = 1'b1;
		repeat (30) @(negedge clk);
		net_exp('{9'h091, 9'h0A0, 9'h003, 9'h000, 9'h0FE, 9'h0FF, 9'h011, 9'h122});
	endtask
	task automatic t_rep;
		send('{8'hFE, 8'h05, 8'h20, 8'h20, 8'h02, 8'h00, 8'h32, 8'hFF});
		host_exp('{8'hFE, 8'h06, 8'h22, 8'h20, 8'h02, 8'h00, 8'hE0, 8'h20, 8'hFF});
		chk1(net_q.size() == 0);
	endtask
	task automatic t_loop;
		send('{8'hFE, 8'h04, 8'h81, 8'h80, 8'h0F, 8'h00, 8'hFF});
		host_exp('{8'hFE, 8'h04, 8'h81, 8'h80, 8'h0F, 8'h00, 8'hFF});
		chk1(net_q.size() == 0);
	endtask
	task automatic t_nin;
		upf_bq_t d;
		d = '{9'h091, 9'h0A0, 9'h005, 9'h000, 9'h1FF};
		foreach (d[i]) begin
			@(negedge clk);
			i_vld = 1'b1;
			i_dat = d[i][7:0];
			i_last = d[i][8];
			while (i_rdy !== 1'b1)
				@(negedge clk);
			@(posedge clk);
		end
		@(negedge clk);
		i_vld = 1'b0;
		i_dat = 8'h00;
		i_last = 1'b0;
		host_exp('{8'hFE, 8'h05, 8'h91, 8'hA0, 8'h05, 8'h00, 8'hFE, 8'hFD, 8'hFF});
	endtask
	task automatic t_led;
		send('{8'hFE, 8'h05, 8'h91, 8'hFE, 8'h05, 8'h91, 8'h20, 8'h00, 8'h00, 8'h03, 8'hFF});
		repeat (60) @(negedge clk);
		chk1(drop_n == 1);
		chk1(led_n >= 30 && led_n <= 31);
		chk1(net_q.size() == 0 && i_host.rx_q.size() == 0);
	endtask
	task automatic summarize;
		$display("mismatches %0d of %0d checks", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		repeat (8) @(negedge clk);
		t_fwd();
		t_rep();
		t_loop();
		fork
			t_nin();
			t_led();
		join
		summarize();
	end
	initial begin
		repeat (120000) @(posedge clk);
		fail_count++;
		summarize();
	end
endmodule
